/* include/lbe_consts.vh */
// Purpose: constants for the latched byte eeprom host controller
// Assumes: 100 MHz CLK_I, 10 ns period
// Notes:   times in their own unit, cycle counts derived from them
// Behaviour
// [R1] memory is 2048 bytes, 11-bit address, bidirectional 8-bit data lines
// [R2] device latches address, data, chip and output enables at write enable fall
// [R3] six modes chosen by chip, output and write enable levels
// [R4] host erases a byte before writing new data into it
// [R5] byte erase: chip enable low, output enable high, all ones on data
// [R6] write enable falling in erase/write setup latches and starts the operation
// [R7] byte erase or write completes under 10 ms on standard part
// [R8] byte write is erase sequence with real data instead of all ones
// [R9] fast variant shortens byte erase and write to 1 ms
// [R10] device accepts logic low or high voltage write enable
// [R11] no timing restriction on write enable rising edge
// [R12] chip erase: erase sequence with high-voltage output enable, whole array
// [R13] erase or write of one byte leaves all other bytes unchanged
// [R14] read: write enable high, chip and output enable low, device drives data
// [R15] chip enable high gives standby, data lines floating, write ignored
// [R16] device refuses write unless chip and output enables match byte write
// [R17] latches reopen only after write recovery; host waits before next cycle
// [R18] host waits at least 2 us after write enable rises before a read
// [R19] host holds write enable low for full pulse sized to variant
`ifndef LBE_CONSTS_VH
`define LBE_CONSTS_VH
`define LBE_ADDR_W        11
`define LBE_DATA_W        8
`define LBE_CLK_NS        10
`define LBE_WP_STD_MS     10
`define LBE_WP_FAST_MS    1
`define LBE_WP_CHIP_MS    10
`define LBE_WP_STD_CYC    (`LBE_WP_STD_MS * 1000000 / `LBE_CLK_NS)
`define LBE_WP_FAST_CYC   (`LBE_WP_FAST_MS * 1000000 / `LBE_CLK_NS)
`define LBE_WP_CHIP_CYC   (`LBE_WP_CHIP_MS * 1000000 / `LBE_CLK_NS)
`define LBE_SETUP_NS      1000
`define LBE_SETUP_CYC     ((`LBE_SETUP_NS + `LBE_CLK_NS - 1) / `LBE_CLK_NS)
`define LBE_REC_US        2
`define LBE_REC_CYC       ((`LBE_REC_US * 1000 + `LBE_CLK_NS - 1) / `LBE_CLK_NS)
`define LBE_ACC_NS        350
`define LBE_ACC_CYC       ((`LBE_ACC_NS + `LBE_CLK_NS - 1) / `LBE_CLK_NS)
`define LBE_PIN_CYC       4
`define LBE_RD_DONE_CYC   (`LBE_ACC_CYC + `LBE_PIN_CYC - 1)
`define LBE_CMD_READ      2'h0
`define LBE_CMD_ERASE     2'h1
`define LBE_CMD_WRITE     2'h2
`define LBE_CMD_CHIP      2'h3
`define LBE_ONES          8'hFF
`endif

/* hw/lbe_host.v */
// Purpose: host controller driving the latched byte eeprom pins
// Assumes: one clock, commands held until accepted by REQ_I/BUSY_O
// Notes:   high-voltage output enable for chip erase is a separate pin strobe;
//          a byte write runs an erase pass then a write pass, about twice as long;
//          fast variant shortens byte passes only, chip erase keeps the long pulse
`timescale 1ns/1ps
`include "lbe_consts.vh"
module lbe_host #(
   parameter WP_STD_CYC  = `LBE_WP_STD_CYC,
   parameter WP_FAST_CYC = `LBE_WP_FAST_CYC,
   parameter WP_CHIP_CYC = `LBE_WP_CHIP_CYC
)(
   input  wire        CLK_I,
   input  wire        NRST_I,
   input  wire        REQ_I,
   input  wire [1:0]  CMD_I,
   input  wire [10:0] ADDR_I,
   input  wire [7:0]  WDATA_I,
   input  wire        FAST_I,
   output reg         BUSY_O,
   output reg         DONE_O,
   output reg  [7:0]  RDATA_O,
   output reg         CE_N_O,
   output reg         OE_N_O,
   output reg         OE_HV_O,
   output reg         WE_N_O,
   output reg  [10:0] BYTE_ADDRESS_O,
   output reg  [7:0]  DATA_LINES_O,
   output reg         DATA_LINES_OE_O,
   input  wire [7:0]  DATA_LINES_I
);
   localparam S_IDLE  = 5'b00001;
   localparam S_SETUP = 5'b00010;
   localparam S_PULSE = 5'b00100;
   localparam S_REC   = 5'b01000;
   localparam S_READ  = 5'b10000;

   reg [4:0]  state_q;
   reg [20:0] cnt_q;
   reg [1:0]  cmd_q;
   reg        fast_q;
   reg        erase_first_q;
   reg [7:0]  wdata_q;
   wire [7:0] pin_data;
   // counter widened so compares meet the 32-bit constants
   wire [31:0] cnt_w = {11'h000, cnt_q};
   // [R19] pulse end per variant; chip erase ignores the fast pin
   wire       pulse_last = (cmd_q == `LBE_CMD_CHIP) ? (cnt_w == WP_CHIP_CYC - 1) :
                           fast_q                   ? (cnt_w == WP_FAST_CYC - 1) :
                                                      (cnt_w == WP_STD_CYC - 1);

   ////////////////////////////////////////////////////////////////////////////
   // pin input sampling: a bit counts once stages two and three agree,
   // so a line still settling after turnaround never reaches the read data
   genvar     gi;
   generate
      for (gi = 0; gi < `LBE_DATA_W; gi = gi + 1)
      begin : g_pin
         reg s1_q;
         reg s2_q;
         reg s3_q;
         reg val_q;
         always @(posedge CLK_I or negedge NRST_I)
         begin
            if (!NRST_I)
            begin
               s1_q  <= 1'b0;
               s2_q  <= 1'b0;
               s3_q  <= 1'b0;
               val_q <= 1'b0;
            end
            else
            begin
               s1_q <= DATA_LINES_I[gi];
               s2_q <= s1_q;
               s3_q <= s2_q;
               if (s2_q == s3_q)
               begin
                  val_q <= s3_q;
               end
            end
         end
         assign pin_data[gi] = val_q;
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   always @(posedge CLK_I or negedge NRST_I)
   begin
      if (!NRST_I)
      begin
         state_q         <= S_IDLE;
         cnt_q           <= 21'h000000;
         cmd_q           <= 2'h0;
         fast_q          <= 1'b0;
         erase_first_q   <= 1'b0;
         wdata_q         <= 8'h00;
         BUSY_O          <= 1'b0;
         DONE_O          <= 1'b0;
         RDATA_O         <= 8'h00;
         // [R15] standby while idle
         CE_N_O          <= 1'b1;
         OE_N_O          <= 1'b1;
         OE_HV_O         <= 1'b0;
         WE_N_O          <= 1'b1;
         BYTE_ADDRESS_O  <= 11'h000;
         DATA_LINES_O    <= 8'h00;
         DATA_LINES_OE_O <= 1'b0;
      end
      else
      begin
         DONE_O <= 1'b0;
         case (state_q)
            S_IDLE:
            begin
               if (REQ_I)
               begin
                  BUSY_O         <= 1'b1;
                  cmd_q          <= CMD_I;
                  fast_q         <= FAST_I;
                  // [R1] 11-bit address
                  BYTE_ADDRESS_O <= ADDR_I;
                  CE_N_O         <= 1'b0;
                  cnt_q          <= 21'h000000;
                  if (CMD_I == `LBE_CMD_READ)
                  begin
                     // [R14] read levels
                     OE_N_O  <= 1'b0;
                     state_q <= S_READ;
                  end
                  else
                  begin
                     // [R5] erase setup: output enable high, all ones
                     OE_N_O          <= 1'b1;
                     // [R12] chip erase raises output enable to high voltage
                     OE_HV_O         <= (CMD_I == `LBE_CMD_CHIP);
                     DATA_LINES_OE_O <= 1'b1;
                     DATA_LINES_O    <= `LBE_ONES;
                     wdata_q         <= WDATA_I;
                     // [R4] write always erases its byte first
                     // costs a second pulse, but no caller can skip it
                     erase_first_q   <= (CMD_I == `LBE_CMD_WRITE);
                     state_q         <= S_SETUP;
                  end
               end
            end
            S_SETUP:
            begin
               cnt_q <= cnt_q + 21'h000001;
               // one setup length for all: the chip erase minimum
               if (cnt_w == (`LBE_SETUP_CYC - 1))
               begin
                  // [R6] falling write enable starts operation
                  WE_N_O  <= 1'b0;
                  cnt_q   <= 21'h000000;
                  state_q <= S_PULSE;
               end
            end
            S_PULSE:
            begin
               cnt_q <= cnt_q + 21'h000001;
               // [R19] full pulse per variant, [R9] fast, [R12] chip erase
               if (pulse_last)
               begin
                  WE_N_O  <= 1'b1;
                  cnt_q   <= 21'h000000;
                  state_q <= S_REC;
               end
            end
            S_REC:
            begin
               // latched inputs are don't care now; release the bus early
               CE_N_O          <= 1'b1;
               OE_HV_O         <= 1'b0;
               DATA_LINES_OE_O <= 1'b0;
               cnt_q           <= cnt_q + 21'h000001;
               // [R17] [R18] recovery before next cycle
               if (cnt_w == (`LBE_REC_CYC - 1))
               begin
                  // recovery over: latches open again
                  cnt_q <= 21'h000000;
                  if (erase_first_q)
                  begin
                     // [R8] second pass: same setup, real data this time
                     erase_first_q   <= 1'b0;
                     CE_N_O          <= 1'b0;
                     DATA_LINES_OE_O <= 1'b1;
                     DATA_LINES_O    <= wdata_q;
                     state_q         <= S_SETUP;
                  end
                  else
                  begin
                     // [R17] next command only after full recovery
                     BUSY_O  <= 1'b0;
                     DONE_O  <= 1'b1;
                     state_q <= S_IDLE;
                  end
               end
            end
            S_READ:
            begin
               cnt_q <= cnt_q + 21'h000001;
               // access time plus the pin sampling stages
               if (cnt_w == `LBE_RD_DONE_CYC)
               begin
                  RDATA_O <= pin_data;
                  CE_N_O  <= 1'b1;
                  OE_N_O  <= 1'b1;
                  BUSY_O  <= 1'b0;
                  DONE_O  <= 1'b1;
                  state_q <= S_IDLE;
               end
            end
            default:
            begin
               state_q <= S_IDLE;
            end
         endcase
      end
   end
endmodule

/* testbench/lbe_props.sv */
// Purpose: pin checks of the eeprom host
// Assumes: pulse parameter of 5 or more
// Notes:   cycle figures follow the hand-over timing
`timescale 1ns/1ps
module lbe_props (
   input wire       CLK_I,
   input wire       NRST_I,
   input wire       REQ_I,
   input wire [1:0] CMD_I,
   input wire       BUSY_O,
   input wire       DONE_O,
   input wire       CE_N_O,
   input wire       OE_N_O,
   input wire       OE_HV_O,
   input wire       WE_N_O,
   input wire       DATA_LINES_OE_O
);
   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (!NRST_I);
   sequence s_open; !CE_N_O && !OE_N_O && WE_N_O; endsequence
   sequence s_low; !WE_N_O [*5]; endsequence
   property p_rd; REQ_I && !BUSY_O && CMD_I == 2'h0 |=> s_open ##39 DONE_O; endproperty
   property p_mode; !WE_N_O |-> !CE_N_O && OE_N_O && DATA_LINES_OE_O; endproperty
   property p_hv; OE_HV_O |-> OE_N_O && !CE_N_O; endproperty
   property p_pulse; $fell(WE_N_O) |-> s_low; endproperty
   property p_rec; $rose(WE_N_O) |-> ##200 (DONE_O || $fell(CE_N_O)); endproperty
   property p_setup; $fell(WE_N_O) |-> !$past(CE_N_O, 100) && $past(CE_N_O, 101); endproperty
   property p_done; DONE_O |-> !BUSY_O ##1 !DONE_O; endproperty
   property p_go; $rose(BUSY_O) |-> !CE_N_O; endproperty
   a_rd: assert property (p_rd) else $error("read late");
   a_mode: assert property (p_mode) else $error("bad pulse mode");
   a_hv: assert property (p_hv) else $error("bad clear mode");
   a_pulse: assert property (p_pulse) else $error("pulse short");
   a_rec: assert property (p_rec) else $error("recovery wrong");
   a_setup: assert property (p_setup) else $error("setup wrong");
   a_done: assert property (p_done) else $error("done wrong");
   a_go: assert property (p_go) else $error("no select");
endmodule
bind lbe_host lbe_props u_props (.*);

/* testbench/lbe_dev.sv */
// Purpose: byte eeprom model on the host pins
// Assumes: erase sets ones, write only clears bits
// Notes:   released lines show the inverse of the last level
`timescale 1ns/1ps
module lbe_dev (
   input  wire        ce_n,
   input  wire        oe_n,
   input  wire        oe_hv,
   input  wire        we_n,
   input  wire [10:0] a,
   input  wire [7:0]  hd,
   input  wire        hoe,
   output wire [7:0]  dq
);
   reg     [7:0] mem [0:2047];
   reg     [7:0] last = 8'h00;
   integer       j;
   wire          rd = !ce_n && !oe_n && we_n;
   assign dq = hoe ? hd : (rd ? mem[a] : ~last);
   always @(dq)
      if (hoe || rd)
         last = dq;
   initial
      for (j = 0; j < 2048; j++) mem[j] = 8'hFF;
   always @(negedge we_n)
      if (!ce_n && oe_n)
      begin
         if (oe_hv)
            for (j = 0; j < 2048; j++) mem[j] = 8'hFF;
         else
            mem[a] = (hd == 8'hFF) ? 8'hFF : (mem[a] & hd);
      end
endmodule

/* testbench/lbe_host_tb.sv */
// Purpose: bench for the eeprom host
// Assumes: short pulse parameters
// Notes:   reads checked from a queue
`timescale 1ns/1ps
module lbe_host_tb;
   reg         clk = 0, rst_n = 0, req = 0, fast = 0, pend = 0;
   reg  [1:0]  cmd = 0;
   reg  [10:0] adr = 0;
   reg  [7:0]  wd = 0;
   reg  [7:0]  ref_m [0:2047];
   reg  [7:0]  exp_q [$];
   reg  [31:0] sd = 19, rv = 0;
   integer     error_cnt = 0, n_checks = 0, i, k;
   wire        busy, done, ce_n, oe_n, hv, we_n, doe;
   wire [7:0]  rd, dout, dq;
   wire [10:0] ba;
   always #5 clk = ~clk;
   lbe_host #(.WP_STD_CYC(20), .WP_FAST_CYC(5), .WP_CHIP_CYC(20)) dut (.CLK_I(clk), .NRST_I(rst_n), .REQ_I(req),
      .CMD_I(cmd), .ADDR_I(adr), .WDATA_I(wd), .FAST_I(fast), .BUSY_O(busy), .DONE_O(done), .RDATA_O(rd),
      .CE_N_O(ce_n), .OE_N_O(oe_n), .OE_HV_O(hv), .WE_N_O(we_n), .BYTE_ADDRESS_O(ba), .DATA_LINES_O(dout),
      .DATA_LINES_OE_O(doe), .DATA_LINES_I(dq));
   lbe_dev dev (.ce_n(ce_n), .oe_n(oe_n), .oe_hv(hv), .we_n(we_n), .a(ba), .hd(dout), .hoe(doe), .dq(dq));
   function [31:0] xs(input [31:0] v);
      xs = v ^ (v << 13);
      xs = xs ^ (xs >> 17);
      xs = xs ^ (xs << 5);
   endfunction
   task check(input [7:0] s, input [7:0] e, input [39:0] nm);
      n_checks++;
      if (s !== e)
      begin
         error_cnt++;
         $display("MISMATCH %0s exp %h seen %h", nm, e, s);
      end
   endtask
   task stop_test;
      $display("checks %0d errors %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task op(input [1:0] c, input [10:0] a, input [7:0] d);
      @(negedge clk);
      sd = xs(sd);
      {req, cmd, adr, wd, fast} = {1'b1, c, a, d, sd[0]};
      if (c == 2'h0)
         exp_q.push_back(ref_m[a]);
      pend = (c == 2'h0);
      // expected contents; a write erases first
      if (c == 2'h3)
         for (k = 0; k < 2048; k++) ref_m[k] = 8'hFF;
      else if (c != 2'h0)
         ref_m[a] = (c == 2'h1) ? 8'hFF : d;
      @(negedge clk);
      req = 0;
      for (k = 0; k < 1000 && done !== 1'b1; k++) @(negedge clk);
      if (k == 1000)
      begin
         error_cnt++;
         stop_test;
      end
      check({7'h0, busy}, 8'h00, "busy");
   endtask
   always @(negedge clk)
      if (done === 1'b1 && pend)
      begin
         check(rd, exp_q.pop_front(), "rdata");
         pend = 0;
      end
   initial
   begin
      for (i = 0; i < 2048; i++) ref_m[i] = 8'hFF;
      repeat (8) @(negedge clk);
      rst_n = 1;
      check({7'h0, ce_n}, 8'h01, "ce_n");
      for (i = 0; i < 6; i++)
      begin
         sd = xs(sd);
         rv = sd;
         op(2'h1, rv[10:0], 8'hFF);
         op(2'h2, rv[10:0], rv[18:11]);
         op(2'h2, rv[10:0], rv[26:19]);
         op(2'h0, rv[10:0], 8'h00);
         op(2'h0, rv[10:0] ^ 11'h001, 8'h00);
      end
      op(2'h2, 11'h7FF, 8'h5A);
      op(2'h0, 11'h7FF, 8'h00);
      op(2'h3, 11'h000, 8'h00);
      op(2'h0, rv[10:0], 8'h00);
      stop_test;
   end
endmodule
